// [lpm_pkg.sv]
// Package for the low power mode controller: register map, field layouts, states, timing.
package lpm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] LPM_OFF_INT_CLOCK = 8'h00;
  localparam logic [7:0] LPM_OFF_CLOCK_DIV = 8'h04;
  localparam logic [7:0] LPM_OFF_PERIPH_GATE = 8'h08;
  localparam logic [7:0] LPM_OFF_WAKE_CTRL = 8'h0C;
  localparam logic [7:0] LPM_OFF_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LPM_BIT_FAST_WAKE = 2;
  localparam int LPM_BIT_REG_OFF = 5;
  localparam int LPM_BIT_AWU_EN = 0;
  localparam int LPM_BIT_BEEPER_OUTPUT_EN = 1;
  localparam int LPM_BIT_WDG_EN = 2;
  localparam int LPM_BIT_LSE_SEL = 3;
  localparam int LPM_BIT_PEND = 16;
  localparam logic [2:0] LPM_DIV_FULL = 3'h0;
  localparam logic [15:0] LPM_GATE_RESET = 16'hFFFF;
  localparam logic [15:0] LPM_AWU_DELAY_RESET = 16'h0100;
  localparam logic [31:0] LPM_ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing: regulator restart and oscillator restart waits
  // ----------------------------------------------------------------
  localparam int LPM_CLK_MHZ = 100;
  localparam int LPM_REG_ON_NS = 1000;
  localparam int LPM_OSC_ON_NS = 200;
  localparam logic [15:0] LPM_REG_ON_CYC = 16'((LPM_REG_ON_NS * LPM_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] LPM_OSC_ON_CYC = 16'((LPM_OSC_ON_NS * LPM_CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // Modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LPM_RUN, LPM_WAIT, LPM_HALT, LPM_ACTIVE_HALT, LPM_REG_RESTART, LPM_OSC_RESTART
  } lpm_mode_t;

  typedef enum logic [1:0] {
    LPM_SRC_HSI = 2'h0, LPM_SRC_HSE = 2'h1, LPM_SRC_LSI = 2'h2
  } lpm_src_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } lpm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lpm_apb_rsp_t;

  typedef struct packed {
    logic cpuClockEn;
    logic masterClockEn;
    logic [15:0] periphClockEn;
    logic mainRegulatorOn;
    logic lowPowerRegulatorOn;
    logic highSpeedOscOn;
    logic lowSpeedOscOn;
    logic crystalOscOn;
    lpm_src_t masterSource;
    logic cpuWake;
  } lpm_power_t;

endpackage

// [lpm_wake_timer.sv]
// Auto-wakeup down counter running while the device is in Active-halt.
`timescale 1ns/1ns
`default_nettype none
module lpm_wake_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic run,
  input wire logic [15:0] delay,
  // Result
  output logic expired
);
  import lpm_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic expired;
  } lpm_timer_state_t;

  lpm_timer_state_t state;
  lpm_timer_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.expired = 1'b0;
    if (start) begin
      next_state.count = delay;
    end else if (run && state.count != 16'h0000) begin
      next_state.count = state.count - 16'h0001;
      next_state.expired = (state.count == 16'h0001);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign expired = state.expired;
endmodule
`default_nettype wire

// [lpm_controller.sv]
// Low power mode controller: mode sequencing, clock and regulator control, APB registers.
//
// What this block does
// (RULE1) Reset leaves the device in Run with CPU and peripheral clocks on.
// (RULE2) A nonzero CPU divider slows only the CPU clock, not master clock.
// (RULE3) Writing divider zero in Run restores full-speed CPU clock.
// (RULE4) Peripheral gating applies in Run and Wait; writable any time.
// (RULE5) Wait instruction stops CPU clock only; regulator and oscillators stay on.
// (RULE6) Wait keeps registers and the reported clock source unchanged.
// (RULE7) Any internal, external interrupt or reset wakes from Wait.
// (RULE8) Halt stops master clock, so CPU and peripherals get no clock.
// (RULE9) Halt instruction enters Halt when auto-wakeup is disabled.
// (RULE10) Only external interrupt or reset wakes from Halt.
// (RULE11) Communication peripheral interrupts count as external wakeups in halts.
// (RULE12) Halt preserves registers and by default the clock source.
// (RULE13) Halt switches main regulator off; low-power regulator stays on.
// (RULE14) Fast wakeup select restarts from halts on the fast internal oscillator.
// (RULE15) With auto-wakeup on, halt enters Active-halt; wakes on delay, interrupt, reset.
// (RULE16) Active-halt stops main oscillator; only slow or crystal osc runs.
// (RULE17) Beeper or watchdog active forces slow internal oscillator on in halts.
// (RULE18) Main regulator stays on in Active-halt by default.
// (RULE19) Regulator-off bit powers main regulator down on Active-halt entry.
// (RULE20) Software uses only slow internal oscillator when regulator-off is set.
// (RULE21) Waking with regulator off re-enables main regulator first, slower; code holds it off through LPM_REG_RESTART, on with the oscillator.
// (RULE22) Software restores its clock source after a fast wakeup.
// (RULE23) Halt chooses Active-halt exactly when auto-wakeup is enabled then.
`timescale 1ns/1ns
`default_nettype none
module lpm_controller (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB register bus
  input wire lpm_pkg::lpm_apb_req_t apbReq,
  output lpm_pkg::lpm_apb_rsp_t apbRsp,
  // CPU instruction strobes
  input wire logic waitInstruction,
  input wire logic haltInstruction,
  // Wakeup sources
  input wire logic internalIrq,
  input wire logic externalIrq,
  input wire logic commIrq,
  // Clock and power controls
  output lpm_pkg::lpm_power_t power,
  output logic [2:0] cpuClockDivider,
  output lpm_pkg::lpm_mode_t modeState
);
  import lpm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lpm_mode_t mode;
    logic [15:0] waitCount;
    logic fastWakeSelect;
    logic regOffInActiveHalt;
    logic [2:0] cpuDiv;
    logic [15:0] periphGate;
    logic awuEnable;
    logic beepActive;
    logic wdgActive;
    logic crystalForAwu;
    logic [15:0] awuDelay;
    lpm_src_t runSource;
    logic wokeFast;
    lpm_apb_rsp_t rsp;
    lpm_power_t power;
  } lpm_state_t;

  lpm_state_t state;
  lpm_state_t next_state;
  logic awuStart;
  logic awuExpired;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic isHalt(input lpm_mode_t m);
    return (m == LPM_HALT) || (m == LPM_ACTIVE_HALT);
  endfunction

  function automatic logic [31:0] readWord(input lpm_state_t s, input logic [7:0] addr);
    logic [31:0] w;
    w = LPM_ZERO_WORD;
    case (addr)
      LPM_OFF_INT_CLOCK: begin
        w[LPM_BIT_FAST_WAKE] = s.fastWakeSelect;
        w[LPM_BIT_REG_OFF] = s.regOffInActiveHalt;
      end
      LPM_OFF_CLOCK_DIV: w[2:0] = s.cpuDiv;
      LPM_OFF_PERIPH_GATE: w[15:0] = s.periphGate;
      LPM_OFF_WAKE_CTRL: begin
        w[LPM_BIT_AWU_EN] = s.awuEnable;
        w[LPM_BIT_BEEPER_OUTPUT_EN] = s.beepActive;
        w[LPM_BIT_WDG_EN] = s.wdgActive;
        w[LPM_BIT_LSE_SEL] = s.crystalForAwu;
        w[31:16] = s.awuDelay;
      end
      LPM_OFF_STATUS: begin
        w[2:0] = s.mode;
        w[5:4] = s.power.masterSource;
        w[8] = s.wokeFast;
      end
      default: w = LPM_ZERO_WORD;
    endcase
    return w;
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    return (addr == LPM_OFF_INT_CLOCK) || (addr == LPM_OFF_CLOCK_DIV) ||
      (addr == LPM_OFF_PERIPH_GATE) || (addr == LPM_OFF_WAKE_CTRL) ||
      (addr == LPM_OFF_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic access;
    logic commit;
    logic haltWake;
    access = apbReq.psel && apbReq.penable && !state.rsp.pready;
    commit = apbReq.psel && apbReq.penable && state.rsp.pready && apbReq.pwrite;
    haltWake = externalIrq || commIrq; // [RULE10] [RULE11]
    next_state = state;
    awuStart = 1'b0;
    next_state.rsp.pready = 1'b0;
    next_state.rsp.pslverr = 1'b0;

    // Register access; one wait state so every answer comes from a flip-flop.
    if (access) begin
      next_state.rsp.pready = 1'b1;
      next_state.rsp.pslverr = !isMapped(apbReq.paddr);
      next_state.rsp.prdata = apbReq.pwrite ? LPM_ZERO_WORD : readWord(state, apbReq.paddr);
    end
    // A write lands only at the edge that completes the transfer, not in the wait state.
    if (commit) begin
      case (apbReq.paddr)
        LPM_OFF_INT_CLOCK: begin
          next_state.fastWakeSelect = apbReq.pwdata[LPM_BIT_FAST_WAKE];
          next_state.regOffInActiveHalt = apbReq.pwdata[LPM_BIT_REG_OFF];
        end
        LPM_OFF_CLOCK_DIV: next_state.cpuDiv = apbReq.pwdata[2:0]; // [RULE3]
        LPM_OFF_PERIPH_GATE: next_state.periphGate = apbReq.pwdata[15:0]; // [RULE4]
        LPM_OFF_WAKE_CTRL: begin
          next_state.awuEnable = apbReq.pwdata[LPM_BIT_AWU_EN];
          next_state.beepActive = apbReq.pwdata[LPM_BIT_BEEPER_OUTPUT_EN];
          next_state.wdgActive = apbReq.pwdata[LPM_BIT_WDG_EN];
          next_state.crystalForAwu = apbReq.pwdata[LPM_BIT_LSE_SEL];
          next_state.awuDelay = apbReq.pwdata[31:16];
        end
        LPM_OFF_STATUS: begin
          // Writing the source field restores the clock after a fast wakeup.
          next_state.runSource = lpm_src_t'(apbReq.pwdata[5:4]); // [RULE22]
          next_state.wokeFast = 1'b0;
        end
        default: next_state.runSource = state.runSource;
      endcase
    end

    // Mode sequencing.
    case (state.mode)
      LPM_RUN: begin
        if (haltInstruction) begin
          awuStart = state.awuEnable;
          next_state.mode = state.awuEnable ? LPM_ACTIVE_HALT : LPM_HALT; // [RULE9] [RULE23]
        end else if (waitInstruction) begin
          next_state.mode = LPM_WAIT; // [RULE5]
        end
      end
      LPM_WAIT: begin
        if (internalIrq || externalIrq || commIrq) begin
          next_state.mode = LPM_RUN; // [RULE7]
        end
      end
      LPM_HALT, LPM_ACTIVE_HALT: begin
        if (haltWake || (state.mode == LPM_ACTIVE_HALT && awuExpired)) begin // [RULE15]
          if (state.fastWakeSelect) begin
            next_state.power.masterSource = LPM_SRC_HSI; // [RULE14]
            next_state.wokeFast = 1'b1;
          end
          next_state.waitCount = LPM_REG_ON_CYC;
          // Without the main regulator on the core cannot run: wait LPM_REG_ON_CYC first, with it still off.
          next_state.mode = next_state.power.mainRegulatorOn ? LPM_OSC_RESTART
            : LPM_REG_RESTART; // [RULE21]
          if (next_state.power.mainRegulatorOn) begin
            next_state.waitCount = LPM_OSC_ON_CYC;
          end
        end
      end
      LPM_REG_RESTART: begin
        if (state.waitCount == 16'h0001) begin
          next_state.mode = LPM_OSC_RESTART;
          next_state.waitCount = LPM_OSC_ON_CYC;
        end else begin
          next_state.waitCount = state.waitCount - 16'h0001;
        end
      end
      LPM_OSC_RESTART: begin
        if (state.waitCount == 16'h0001) begin
          next_state.mode = LPM_RUN;
        end else begin
          next_state.waitCount = state.waitCount - 16'h0001;
        end
      end
      default: next_state.mode = LPM_RUN;
    endcase

    // Source held in Run tracks the software choice unless a fast wake overrode it.
    if (next_state.mode == LPM_RUN && !next_state.wokeFast) begin
      next_state.power.masterSource = next_state.runSource; // [RULE6] [RULE12]
    end

    // Clock and power outputs derived from the next mode.
    next_state.power.cpuClockEn = (next_state.mode == LPM_RUN); // [RULE1] [RULE5]
    next_state.power.masterClockEn = (next_state.mode == LPM_RUN) ||
      (next_state.mode == LPM_WAIT); // [RULE8]
    next_state.power.periphClockEn = next_state.power.masterClockEn ?
      next_state.periphGate : 16'h0000; // [RULE4] [RULE8]
    next_state.power.mainRegulatorOn = !(next_state.mode == LPM_HALT ||
      (next_state.mode == LPM_ACTIVE_HALT && next_state.regOffInActiveHalt) ||
      next_state.mode == LPM_REG_RESTART); // [RULE13] [RULE18] [RULE19]
    next_state.power.lowPowerRegulatorOn = 1'b1;
    next_state.power.highSpeedOscOn = !isHalt(next_state.mode) &&
      (next_state.mode != LPM_REG_RESTART); // [RULE16]
    next_state.power.lowSpeedOscOn = (!isHalt(next_state.mode) &&
      next_state.power.masterSource == LPM_SRC_LSI) ||
      (next_state.mode == LPM_ACTIVE_HALT && !next_state.crystalForAwu) ||
      (next_state.mode == LPM_ACTIVE_HALT && next_state.regOffInActiveHalt) || // [RULE20]
      (isHalt(next_state.mode) && (next_state.beepActive || next_state.wdgActive)); // [RULE17]
    next_state.power.crystalOscOn = (!isHalt(next_state.mode) &&
      next_state.power.masterSource == LPM_SRC_HSE) ||
      (next_state.mode == LPM_ACTIVE_HALT && next_state.crystalForAwu &&
      !next_state.regOffInActiveHalt); // [RULE16]
    next_state.power.cpuWake = (state.mode != LPM_RUN) && (next_state.mode == LPM_RUN);
  end

  // ----------------------------------------------------------------
  // Auto-wakeup counter
  // ----------------------------------------------------------------
  lpm_wake_timer wakeTimer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(awuStart),
    .run(state.mode == LPM_ACTIVE_HALT),
    .delay(state.awuDelay),
    .expired(awuExpired)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.mode <= LPM_RUN; // [RULE1]
      state.periphGate <= LPM_GATE_RESET;
      state.cpuDiv <= LPM_DIV_FULL;
      state.awuDelay <= LPM_AWU_DELAY_RESET;
      state.runSource <= LPM_SRC_HSI;
      state.power.cpuClockEn <= 1'b1;
      state.power.masterClockEn <= 1'b1;
      state.power.periphClockEn <= LPM_GATE_RESET;
      state.power.mainRegulatorOn <= 1'b1;
      state.power.lowPowerRegulatorOn <= 1'b1;
      state.power.highSpeedOscOn <= 1'b1;
      state.power.masterSource <= LPM_SRC_HSI;
    end else begin
      state <= next_state;
    end
  end

  // The divider only reaches the CPU clock; master clock is never divided.
  assign cpuClockDivider = state.cpuDiv; // [RULE2]
  assign power = state.power;
  assign apbRsp = state.rsp;
  assign modeState = state.mode;
endmodule
`default_nettype wire

// [lpm_controller_properties.sv]
// Checker of mode, clock and regulator behaviour at the controller ports.
`timescale 1ns/1ns
`default_nettype none
module lpm_controller_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus, strobes and wakeups
  input wire lpm_pkg::lpm_apb_req_t apbReq,
  input wire lpm_pkg::lpm_apb_rsp_t apbRsp,
  input wire logic waitInstruction,
  input wire logic haltInstruction,
  input wire logic internalIrq,
  input wire logic externalIrq,
  input wire logic commIrq,
  // Controls
  input wire lpm_pkg::lpm_power_t power,
  input wire lpm_pkg::lpm_mode_t modeState
);
  import lpm_pkg::*;
  logic [5:0] ick;
  logic [3:0] wake;
  logic [15:0] gate;
  logic wr;
  logic halted;
  assign wr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
  assign halted = modeState inside {LPM_HALT, LPM_ACTIVE_HALT};
  // Shadow copies of the settings, taken at the same edge the registers take them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ick <= 6'h00;
      wake <= 4'h0;
      gate <= LPM_GATE_RESET;
    end else if (wr) begin
      if (apbReq.paddr == LPM_OFF_INT_CLOCK) ick <= apbReq.pwdata[5:0];
      if (apbReq.paddr == LPM_OFF_WAKE_CTRL) wake <= apbReq.pwdata[3:0];
      if (apbReq.paddr == LPM_OFF_PERIPH_GATE) gate <= apbReq.pwdata[15:0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  property p_gate; power.masterClockEn && $past(power.masterClockEn) && $stable(gate)
    |-> power.periphClockEn == gate; endproperty
  a_gate: assert property (p_gate) else $error("gated clocks differ");
  property p_wait_in; modeState == LPM_RUN && waitInstruction && !haltInstruction |=>
    modeState == LPM_WAIT && !power.cpuClockEn && power.masterClockEn && power.mainRegulatorOn
    && $stable({power.highSpeedOscOn, power.lowSpeedOscOn, power.crystalOscOn}); endproperty
  a_wait_in: assert property (p_wait_in) else $error("bad wait entry");
  property p_wait_src; modeState == LPM_WAIT |-> $stable(power.masterSource); endproperty
  a_wait_src: assert property (p_wait_src) else $error("source moved in wait");
  property p_wait_wake; modeState == LPM_WAIT && (internalIrq || externalIrq)
    |=> modeState == LPM_RUN; endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("no wake from wait");
  property p_halt_off; modeState == LPM_HALT |-> !power.masterClockEn && !power.cpuClockEn
    && power.periphClockEn == 16'h0000 && !power.mainRegulatorOn && power.lowPowerRegulatorOn;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt left power on");
  property p_halt_pick; modeState == LPM_RUN && haltInstruction
    |=> modeState == (wake[LPM_BIT_AWU_EN] ? LPM_ACTIVE_HALT : LPM_HALT); endproperty
  a_halt_pick: assert property (p_halt_pick) else $error("wrong halt kind");
  property p_halt_hold; modeState == LPM_HALT && !externalIrq && !commIrq
    |=> modeState == LPM_HALT; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left alone");
  property p_ahalt; modeState == LPM_ACTIVE_HALT |-> !power.cpuClockEn && !power.highSpeedOscOn
    && power.mainRegulatorOn == !ick[LPM_BIT_REG_OFF]; endproperty
  a_ahalt: assert property (p_ahalt) else $error("bad active halt");
  property p_lsi; halted && |wake[2:1] |-> power.lowSpeedOscOn; endproperty
  a_lsi: assert property (p_lsi) else $error("slow oscillator off");
  property p_fast; power.cpuWake && ick[LPM_BIT_FAST_WAKE] && $past(modeState) == LPM_OSC_RESTART
    |-> power.masterSource == LPM_SRC_HSI; endproperty
  a_fast: assert property (p_fast) else $error("fast wake source wrong");
endmodule
bind lpm_controller lpm_controller_checker lpm_controller_checker_inst (.ref_clk(ref_clk),
  .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .waitInstruction(waitInstruction),
  .haltInstruction(haltInstruction), .internalIrq(internalIrq), .externalIrq(externalIrq),
  .commIrq(commIrq), .power(power), .modeState(modeState));
`default_nettype wire

// [lpm_cpu_model.sv]
// Behavioural core and interrupt controller facing the mode controller.
`timescale 1ns/1ns
`default_nettype none
module lpm_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Wake indication
  input wire logic cpuWake,
  // Instructions and interrupt levels: internal, external, communication
  output logic waitInstruction,
  output logic haltInstruction,
  output logic [2:0] irq
);
  initial begin
    waitInstruction = 1'b0;
    haltInstruction = 1'b0;
    irq = 3'h0;
  end
  task automatic execute(input logic halt);
    @(posedge ref_clk);
    waitInstruction <= !halt;
    haltInstruction <= halt;
    @(posedge ref_clk);
    waitInstruction <= 1'b0;
    haltInstruction <= 1'b0;
  endtask
  // A pending request stays up until the core wakes or limit edges have passed, whichever comes first.
  task automatic request(input int src, input int limit, output int waited);
    @(posedge ref_clk);
    if (src < 3) irq[src] <= 1'b1;
    waited = 0;
    do begin
      @(posedge ref_clk);
      waited++;
    end while (cpuWake !== 1'b1 && waited < limit);
    irq <= 3'h0;
  endtask
endmodule
`default_nettype wire

// [low_power_mode_control_test.sv]
// Self-checking bench for the low power mode controller.
`timescale 1ns/1ns
`default_nettype none
module low_power_mode_control_test;
  import lpm_pkg::*;
  logic ref_clk;
  logic rst_n;
  lpm_apb_req_t apbReq;
  lpm_apb_rsp_t apbRsp;
  logic waitInstruction;
  logic haltInstruction;
  logic [2:0] irq;
  lpm_power_t power;
  logic [2:0] cpuClockDivider;
  lpm_mode_t modeState;
  int failures;
  int n_compared;
  int waited;
  logic [31:0] seed = 32'h0000_cfd9;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  logic [7:0] regAddr [5] = '{LPM_OFF_CLOCK_DIV, LPM_OFF_PERIPH_GATE, LPM_OFF_WAKE_CTRL,
    LPM_OFF_STATUS, 8'h20};
  logic [31:0] regVal [5] = '{LPM_ZERO_WORD, {16'h0000, LPM_GATE_RESET},
    {LPM_AWU_DELAY_RESET, 16'h0000}, LPM_ZERO_WORD, LPM_ZERO_WORD};
  int srcT [5] = '{2, 1, 0, 0, 1};
  int wakeT [5] = '{1, 2, 3, 1, 2};
  logic [4:0] awuT = 5'b1_1100;
  logic [4:0] regOffT = 5'b0_1000;
  logic [4:0] fastT = 5'b0_1010;
  logic [4:0] lsiT = 5'b0_1001;
  lpm_controller lpm_controller_inst (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(apbReq),
    .apbRsp(apbRsp), .waitInstruction(waitInstruction), .haltInstruction(haltInstruction),
    .internalIrq(irq[0]), .externalIrq(irq[1]), .commIrq(irq[2]), .power(power),
    .cpuClockDivider(cpuClockDivider), .modeState(modeState));
  lpm_cpu_model lpm_cpu_model_inst (.ref_clk(ref_clk), .cpuWake(power.cpuWake),
    .waitInstruction(waitInstruction), .haltInstruction(haltInstruction), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic lpm_mode_t haltMode(input logic auto_wakeup_unit);
    return auto_wakeup_unit ? LPM_ACTIVE_HALT : LPM_HALT;
  endfunction
  // Edges from raising the request to seeing the wake pulse.
  function automatic int wakeCycles(input logic regOff);
    return 2 + int'(LPM_OSC_ON_CYC) + (regOff ? int'(LPM_REG_ON_CYC) : 0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    apbReq = '0;
    rst_n = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk({modeState, power.cpuClockEn, power.masterClockEn}, {LPM_RUN, 2'b11});
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, regAddr[i], LPM_ZERO_WORD);
      chk(rd, regVal[i]);
      chk(err, i == 4);
    end
    repeat (4) begin
      v = rnd();
      apb(1'b1, LPM_OFF_CLOCK_DIV, {29'h0, v[2:0] | 3'h1});
      repeat (2) @(negedge ref_clk);
      chk({cpuClockDivider, power.masterClockEn, power.periphClockEn},
        {v[2:0] | 3'h1, 1'b1, LPM_GATE_RESET});
    end
    apb(1'b1, LPM_OFF_CLOCK_DIV, LPM_ZERO_WORD);
    repeat (2) @(negedge ref_clk);
    chk(cpuClockDivider, LPM_DIV_FULL);
    for (int s = 0; s < 2; s++) begin
      lpm_cpu_model_inst.execute(1'b0);
      @(negedge ref_clk);
      chk({modeState, power.cpuClockEn, power.masterClockEn}, {LPM_WAIT, 2'b01});
      v = rnd();
      apb(1'b1, LPM_OFF_PERIPH_GATE, {16'h0000, v[15:0]});
      repeat (2) @(negedge ref_clk);
      chk({modeState, power.periphClockEn, power.masterSource},
        {LPM_WAIT, v[15:0], LPM_SRC_HSI});
      lpm_cpu_model_inst.request(s, 50, waited);
      @(negedge ref_clk);
      chk({modeState, power.cpuClockEn}, {LPM_RUN, 1'b1});
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, LPM_OFF_INT_CLOCK, {26'h0, regOffT[i], 2'b00, fastT[i], 2'b00});
      apb(1'b1, LPM_OFF_STATUS, {26'h0, 2'(srcT[i]), 4'h0});
      apb(1'b1, LPM_OFF_WAKE_CTRL, {16'h0064, 12'h000, i == 4, lsiT[i] & i[0],
        lsiT[i] & !i[0], awuT[i]});
      lpm_cpu_model_inst.execute(1'b1);
      @(negedge ref_clk);
      chk({modeState, power.mainRegulatorOn, power.lowPowerRegulatorOn},
        {haltMode(awuT[i]), awuT[i] & !regOffT[i], 1'b1});
      chk({power.cpuClockEn, power.masterClockEn, power.periphClockEn, power.highSpeedOscOn},
        19'h0_0000);
      chk({power.lowSpeedOscOn, power.crystalOscOn},
        {lsiT[i] | awuT[i] & (i != 4), i == 4});
      lpm_cpu_model_inst.request(0, 30, waited);
      @(negedge ref_clk);
      chk({modeState, 8'(waited)}, {haltMode(awuT[i]), 8'h1e});
      lpm_cpu_model_inst.request(wakeT[i], 400, waited);
      @(negedge ref_clk);
      chk({modeState, power.masterSource},
        {LPM_RUN, fastT[i] ? LPM_SRC_HSI : lpm_src_t'(srcT[i])});
      if (wakeT[i] < 3) chk(waited, wakeCycles(!awuT[i] | regOffT[i]));
      chk(power.crystalOscOn, !fastT[i] && srcT[i] == 1);
    end
    // A reset in the middle of Active-halt must bring the device straight back to Run.
    lpm_cpu_model_inst.execute(1'b1);
    @(negedge ref_clk);
    chk(modeState, LPM_ACTIVE_HALT);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk({modeState, power.cpuClockEn, power.masterClockEn, power.mainRegulatorOn,
      power.masterSource}, {LPM_RUN, 3'b111, LPM_SRC_HSI});
    apb(1'b0, LPM_OFF_WAKE_CTRL, LPM_ZERO_WORD);
    chk(rd, {LPM_AWU_DELAY_RESET, 16'h0000});
    summarize();
  end
  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
